// ==== common/ramp_stop_consts.svh ====
`ifndef RAMP_STOP_CONSTS_SVH
`define RAMP_STOP_CONSTS_SVH
// register byte offsets
`define OFS_CFG 8'h00
`define OFS_ARC 8'h04
`define OFS_T1 8'h08
`define OFS_T2 8'h0C
`define OFS_T3 8'h10
`define OFS_SWF 8'h14
`define OFS_DCB 8'h18
`define OFS_BRK 8'h1C
`define OFS_DEAD 8'h20
`define OFS_STAT 8'h24
// reset values
`define RST_CFG 32'h0000_1181
`define RST_ARC 32'h0A0A_0A0A
`define RST_TIME 32'h00C8_00C8
`define RST_SWF 32'h0000_0000
`define RST_DCB 32'h000A_0000
`define RST_BRK 32'h000C_00C8
`define RST_DEAD 32'h0000_0000
// setting limits
`define ARC_MAX 8'h32
`define TIME_MAX 16'h7D00
`define OHM_MIN 16'h000A
`define OHM_MAX 16'h2710
`define KW_MIN 16'h0001
`define KW_MAX 16'h0BB8
`define DEAD_MAX 16'h00FA
`define POL_MAX 3'h4
// timing
`define CLK_PERIOD_NS 5
`define TENTH_S_NS 100000000
`define RAMP_STEP_NS 1000
`define RAMP_STEP_CYCLES (`RAMP_STEP_NS / `CLK_PERIOD_NS)
// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ==== common/ramp_stop_pkg.sv ====
package ramp_stop_pkg;
	typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_DEAD, ST_DECEL, ST_DCB, ST_COAST} run_type;
	typedef struct packed {
		logic [1:0] mode;
		logic freq_ai1;
		logic curve2;
		logic [1:0] regen_brake_sel;
		logic [2:0] fwd_rev_conflict_policy;
		logic [1:0] stop_pattern_sel;
		logic [1:0] direction_prohibit;
		logic [1:0] ramp_shape_set1;
		logic [1:0] ramp_set_select;
	} cfg_type;
	typedef struct packed {
		logic [7:0] s_upper_arc_pct_set3;
		logic [7:0] s_lower_arc_pct_set3;
		logic [7:0] s_upper_arc_pct_set1;
		logic [7:0] s_lower_arc_pct_set1;
	} arc_type;
	typedef struct packed {
		logic [15:0] decel;
		logic [15:0] accel;
	} times_type;
endpackage : ramp_stop_pkg

// ==== rtl/ramp_stop_direction_ctrl.sv ====
`include "ramp_stop_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module ramp_stop_direction_ctrl import ramp_stop_pkg::*; #(
	parameter int unsigned TENTH_S_CYCLES = `TENTH_S_NS / `CLK_PERIOD_NS
) (
	// clock and reset
	input wire logic CLK,
	input wire logic SRST,
	// axi4-lite write
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	// axi4-lite read
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// terminal pins
	input wire logic FWD_CMD,
	input wire logic REV_CMD,
	input wire logic JOG_CMD,
	input wire logic RAMP_SEL_FN5,
	input wire logic RAMP_SEL_FN64,
	// drive internals
	input wire logic [1:0] CMD_SOURCE,
	input wire logic [15:0] OUT_FREQ,
	input wire logic REF_ZERO,
	input wire logic MOTOR_STOPPED,
	// ramp outputs
	output logic [1:0] ACTIVE_SET,
	output logic [15:0] ACCEL_TIME,
	output logic [15:0] DECEL_TIME,
	output logic [7:0] LOWER_ARC,
	output logic [7:0] UPPER_ARC,
	output logic [1:0] RAMP_SHAPE,
	// run outputs
	output logic RUN_FWD,
	output logic RUN_REV,
	output logic RAMP_STOP,
	output logic COAST,
	output logic DC_BRAKE,
	// braking outputs
	output logic REGEN_EN,
	output logic RES_PROTECT,
	output logic [15:0] BRK_OHMS,
	output logic [15:0] BRK_POWER
);
	// ==========================================
	// helpers
	function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
		clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction : clamp16

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		merge = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				merge[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
	endfunction : merge

	function automatic logic [7:0] arc(input logic [7:0] v);
		arc = (v > `ARC_MAX) ? `ARC_MAX : v;
	endfunction : arc

	function automatic logic [31:0] tclamp(input logic [31:0] v);
		tclamp = {clamp16(v[31:16], 16'h0000, `TIME_MAX), clamp16(v[15:0], 16'h0000, `TIME_MAX)};
	endfunction : tclamp

	// ==========================================
	// state
	typedef struct packed {
		logic [3:0] s5, s64, sfwd, srev, sjog;
		logic awready, wready, bvalid, arready, rvalid;
		logic [1:0] bresp, rresp;
		logic [31:0] rdata;
		logic aw_held, w_held;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		cfg_type cfg;
		arc_type arcs;
		times_type t1, t2, t3;
		logic [31:0] swf, dcb, brk;
		logic [7:0] dead;
		logic [15:0] step_cnt;
		logic [1:0] set;
		logic fwd_d, rev_d, first_rev, last_rev;
		run_type run;
		logic dir_rev, coast_src;
		logic [31:0] pre_cnt;
		logic [15:0] tenths;
		logic [1:0] o_set;
		logic [15:0] o_acc, o_dec;
		logic [7:0] o_lo, o_hi;
		logic [1:0] o_shape;
		logic o_fwd, o_rev, o_stop, o_coast, o_dcb, o_regen, o_prot;
		logic [15:0] o_ohm, o_kw;
	} state_type;

	state_type q, d;

	// filtered terminal levels: a change counts once stages 2 and 3 agree
	logic f5, f64, ffwd, frev, fjog;
	logic [1:0] want_set;
	logic cmd_fwd, cmd_rev, want_run, want_rev, dcb_ok, tenth_tick, skip_dead;
	logic [15:0] swa, swb;

	// ==========================================
	// ramp set selection and command settle
	always_comb begin
		swa = q.swf[15:0];
		swb = q.swf[31:16];
		want_set = 2'h1;
		unique case (q.cfg.mode)
			2'h0: want_set = (q.cfg.ramp_set_select == 2'h0) ? 2'h1 : q.cfg.ramp_set_select;
			2'h1: begin
				if (swb != 16'h0000 && OUT_FREQ > swb) begin
					want_set = 2'h3;
				end else if (swa != 16'h0000 && OUT_FREQ > swa) begin
					want_set = 2'h2;
				end
			end
			2'h2: want_set = f64 ? 2'h3 : (f5 ? 2'h2 : 2'h1);
			2'h3: begin
				if (OUT_FREQ > swb) begin
					want_set = 2'h3;
				end else if (OUT_FREQ <= swa) begin
					want_set = f5 ? 2'h2 : 2'h1;
				end else begin
					want_set = f5 ? 2'h1 : 2'h2;
				end
			end
		endcase
		// both commands: policy decides, 4 is taken as forward
		cmd_fwd = ffwd;
		cmd_rev = frev;
		if (ffwd && frev) begin
			unique case (q.cfg.fwd_rev_conflict_policy)
				3'h0: cmd_fwd = 1'b0;
				3'h1: begin
					cmd_fwd = 1'b0;
					cmd_rev = 1'b0;
				end
				3'h2: cmd_fwd = !q.first_rev;
				3'h3: cmd_fwd = !q.last_rev;
				default: cmd_rev = 1'b0;
			endcase
			if (q.cfg.fwd_rev_conflict_policy >= 3'h2) begin
				cmd_rev = !cmd_fwd;
			end
		end
		if (q.cfg.direction_prohibit == 2'h1) begin
			cmd_rev = 1'b0;
		end
		if (q.cfg.direction_prohibit == 2'h2) begin
			cmd_fwd = 1'b0;
		end
		want_run = cmd_fwd || cmd_rev;
		// curve 2 keeps direction at 0 Hz, elsewhere the command rules
		want_rev = (q.cfg.freq_ai1 && q.cfg.curve2 && REF_ZERO) ? q.dir_rev : cmd_rev;
		skip_dead = fjog || (q.cfg.freq_ai1 && q.cfg.curve2) || q.dead == 8'h00;
		dcb_ok = q.dcb[15:0] != 16'h0000 && q.dcb[31:16] != 16'h0000;
		tenth_tick = q.pre_cnt == 32'(TENTH_S_CYCLES - 1);
	end

	assign f5 = q.s5[3];
	assign f64 = q.s64[3];
	assign ffwd = q.sfwd[3];
	assign frev = q.srev[3];
	assign fjog = q.sjog[3];

	// ==========================================
	// next state
	always_comb begin
		d = q;
		// three-stage synchronisers, level taken when stages 2 and 3 agree
		d.s5 = {(q.s5[2] == q.s5[1]) ? q.s5[2] : q.s5[3], q.s5[1], q.s5[0], RAMP_SEL_FN5};
		d.s64 = {(q.s64[2] == q.s64[1]) ? q.s64[2] : q.s64[3], q.s64[1], q.s64[0],
			RAMP_SEL_FN64};
		d.sfwd = {(q.sfwd[2] == q.sfwd[1]) ? q.sfwd[2] : q.sfwd[3], q.sfwd[1], q.sfwd[0],
			FWD_CMD};
		d.srev = {(q.srev[2] == q.srev[1]) ? q.srev[2] : q.srev[3], q.srev[1], q.srev[0],
			REV_CMD};
		d.sjog = {(q.sjog[2] == q.sjog[1]) ? q.sjog[2] : q.sjog[3], q.sjog[1], q.sjog[0],
			JOG_CMD};
		// arrival order of the two direction commands
		d.fwd_d = ffwd;
		d.rev_d = frev;
		if (ffwd && !q.fwd_d && !(frev && !q.rev_d)) begin
			d.last_rev = 1'b0;
			if (!frev) begin
				d.first_rev = 1'b0;
			end
		end
		if (frev && !q.rev_d && !(ffwd && !q.fwd_d)) begin
			d.last_rev = 1'b1;
			if (!ffwd) begin
				d.first_rev = 1'b1;
			end
		end
		// write channel: address and data taken in either order
		if (S_AXI_AWVALID && q.awready) begin
			d.aw_held = 1'b1;
			d.awaddr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && q.wready) begin
			d.w_held = 1'b1;
			d.wdata = S_AXI_WDATA;
			d.wstrb = S_AXI_WSTRB;
		end
		if (q.bvalid && S_AXI_BREADY) begin
			d.bvalid = 1'b0;
		end
		if (q.aw_held && q.w_held && !q.bvalid) begin
			d.aw_held = 1'b0;
			d.w_held = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = `RESP_OKAY;
			// out-of-range settings are clamped, not refused
			unique case (q.awaddr)
				`OFS_CFG: d.cfg = cfg_type'(merge(32'(q.cfg), q.wdata, q.wstrb));
				`OFS_ARC: begin
					d.arcs = arc_type'(merge(q.arcs, q.wdata, q.wstrb));
					d.arcs.s_lower_arc_pct_set1 = arc(d.arcs.s_lower_arc_pct_set1);
					d.arcs.s_upper_arc_pct_set1 = arc(d.arcs.s_upper_arc_pct_set1);
					d.arcs.s_lower_arc_pct_set3 = arc(d.arcs.s_lower_arc_pct_set3);
					d.arcs.s_upper_arc_pct_set3 = arc(d.arcs.s_upper_arc_pct_set3);
				end
				`OFS_T1: d.t1 = times_type'(tclamp(merge(q.t1, q.wdata, q.wstrb)));
				`OFS_T2: d.t2 = times_type'(tclamp(merge(q.t2, q.wdata, q.wstrb)));
				`OFS_T3: d.t3 = times_type'(tclamp(merge(q.t3, q.wdata, q.wstrb)));
				`OFS_SWF: d.swf = merge(q.swf, q.wdata, q.wstrb);
				`OFS_DCB: d.dcb = merge(q.dcb, q.wdata, q.wstrb);
				`OFS_BRK: begin
					d.brk = merge(q.brk, q.wdata, q.wstrb);
					d.brk[15:0] = clamp16(d.brk[15:0], `OHM_MIN, `OHM_MAX);
					d.brk[31:16] = clamp16(d.brk[31:16], `KW_MIN, `KW_MAX);
				end
				`OFS_DEAD: d.dead = 8'(clamp16(16'(merge(32'(q.dead), q.wdata,
					q.wstrb) & 32'h0000_00FF), 16'h0000, `DEAD_MAX));
				default: d.bresp = `RESP_SLVERR;
			endcase
		end
		if (d.cfg.fwd_rev_conflict_policy > `POL_MAX) begin
			d.cfg.fwd_rev_conflict_policy = `POL_MAX;
		end
		d.awready = !d.aw_held && !d.bvalid;
		d.wready = !d.w_held && !d.bvalid;
		// read channel, one outstanding
		if (q.rvalid && S_AXI_RREADY) begin
			d.rvalid = 1'b0;
		end
		if (S_AXI_ARVALID && q.arready) begin
			d.rvalid = 1'b1;
			d.rresp = `RESP_OKAY;
			unique case (S_AXI_ARADDR)
				`OFS_CFG: d.rdata = 32'(q.cfg);
				`OFS_ARC: d.rdata = q.arcs;
				`OFS_T1: d.rdata = q.t1;
				`OFS_T2: d.rdata = q.t2;
				`OFS_T3: d.rdata = q.t3;
				`OFS_SWF: d.rdata = q.swf;
				`OFS_DCB: d.rdata = q.dcb;
				`OFS_BRK: d.rdata = q.brk;
				`OFS_DEAD: d.rdata = 32'(q.dead);
				`OFS_STAT: d.rdata = {16'h0000, 5'h00, 3'(q.run), q.o_dcb, q.o_coast,
					q.o_stop, q.o_rev, q.o_fwd, q.dir_rev, q.set};
				default: begin
					d.rdata = 32'h0000_0000;
					d.rresp = `RESP_SLVERR;
				end
			endcase
		end
		d.arready = !d.rvalid;
		// ramp set latched on step boundaries so the rate never glitches
		d.step_cnt = q.step_cnt + 16'h0001;
		if (q.step_cnt == 16'(`RAMP_STEP_CYCLES - 1)) begin
			d.step_cnt = 16'h0000;
			d.set = want_set;
		end
		// tenth-second time base for dead time and dc braking
		d.pre_cnt = tenth_tick ? 32'h0000_0000 : q.pre_cnt + 32'h0000_0001;
		if (tenth_tick && q.tenths != 16'h0000) begin
			d.tenths = q.tenths - 16'h0001;
		end
		// run sequencer
		unique case (q.run)
			ST_IDLE: begin
				if (want_run) begin
					d.run = ST_RUN;
					d.dir_rev = want_rev;
				end
			end
			ST_RUN: begin
				d.coast_src = (q.cfg.stop_pattern_sel == 2'h1 && CMD_SOURCE == 2'h0) ||
					(q.cfg.stop_pattern_sel == 2'h2 && CMD_SOURCE == 2'h1) ||
					(q.cfg.stop_pattern_sel == 2'h3 && CMD_SOURCE == 2'h2);
				if (!want_run) begin
					d.run = d.coast_src ? ST_COAST : ST_DECEL;
				end else if (want_rev != q.dir_rev) begin
					d.dir_rev = want_rev;
					if (!skip_dead) begin
						d.run = ST_DEAD;
						d.tenths = 16'(q.dead);
						d.pre_cnt = 32'h0000_0000;
					end
				end
			end
			ST_DEAD: begin
				if (!want_run) begin
					d.run = ST_DECEL;
				end else if (q.tenths == 16'h0000) begin
					d.run = ST_RUN;
				end
			end
			ST_DECEL: begin
				if (q.cfg.stop_pattern_sel == 2'h0 && dcb_ok && OUT_FREQ <= q.dcb[15:0]) begin
					d.run = ST_DCB;
					d.tenths = q.dcb[31:16];
					d.pre_cnt = 32'h0000_0000;
				end else if (MOTOR_STOPPED) begin
					d.run = ST_IDLE;
				end
			end
			ST_DCB: begin
				if (q.tenths == 16'h0000) begin
					d.run = ST_IDLE;
				end
			end
			ST_COAST: begin
				if (MOTOR_STOPPED) begin
					d.run = ST_IDLE;
				end
			end
		endcase
		// registered outputs
		d.o_set = q.set;
		d.o_acc = (q.set == 2'h3) ? q.t3.accel : ((q.set == 2'h2) ? q.t2.accel : q.t1.accel);
		d.o_dec = (q.set == 2'h3) ? q.t3.decel : ((q.set == 2'h2) ? q.t2.decel : q.t1.decel);
		d.o_lo = (q.set == 2'h3) ? q.arcs.s_lower_arc_pct_set3 : q.arcs.s_lower_arc_pct_set1;
		d.o_hi = (q.set == 2'h3) ? q.arcs.s_upper_arc_pct_set3 : q.arcs.s_upper_arc_pct_set1;
		d.o_shape = (q.set == 2'h1) ? q.cfg.ramp_shape_set1 : 2'h0;
		d.o_fwd = (q.run == ST_RUN) && !q.dir_rev;
		d.o_rev = (q.run == ST_RUN) && q.dir_rev;
		d.o_stop = (q.run == ST_DECEL) || (q.run == ST_DEAD);
		d.o_coast = q.run == ST_COAST;
		d.o_dcb = q.run == ST_DCB;
		d.o_regen = q.cfg.regen_brake_sel != 2'h0;
		d.o_prot = q.cfg.regen_brake_sel == 2'h1;
		d.o_ohm = q.brk[15:0];
		d.o_kw = q.brk[31:16];
		if (SRST) begin
			d = '0;
			d.cfg = cfg_type'(`RST_CFG);
			d.arcs = `RST_ARC;
			d.t1 = `RST_TIME;
			d.t2 = `RST_TIME;
			d.t3 = `RST_TIME;
			d.swf = `RST_SWF;
			d.dcb = `RST_DCB;
			d.brk = `RST_BRK;
			// braking copies show the defaults at once, not zero
			d.o_ohm = d.brk[15:0];
			d.o_kw = d.brk[31:16];
			d.dead = 8'(`RST_DEAD);
			d.set = 2'h1;
			d.o_set = 2'h1;
			d.run = ST_IDLE;
		end
	end

	// ==========================================
	// one register for all state
	always_ff @(posedge CLK) begin
		q <= d;
	end

	assign S_AXI_AWREADY = q.awready;
	assign S_AXI_WREADY = q.wready;
	assign S_AXI_BRESP = q.bresp;
	assign S_AXI_BVALID = q.bvalid;
	assign S_AXI_ARREADY = q.arready;
	assign S_AXI_RDATA = q.rdata;
	assign S_AXI_RRESP = q.rresp;
	assign S_AXI_RVALID = q.rvalid;
	assign ACTIVE_SET = q.o_set;
	assign ACCEL_TIME = q.o_acc;
	assign DECEL_TIME = q.o_dec;
	assign LOWER_ARC = q.o_lo;
	assign UPPER_ARC = q.o_hi;
	assign RAMP_SHAPE = q.o_shape;
	assign RUN_FWD = q.o_fwd;
	assign RUN_REV = q.o_rev;
	assign RAMP_STOP = q.o_stop;
	assign COAST = q.o_coast;
	assign DC_BRAKE = q.o_dcb;
	assign REGEN_EN = q.o_regen;
	assign RES_PROTECT = q.o_prot;
	assign BRK_OHMS = q.o_ohm;
	assign BRK_POWER = q.o_kw;
endmodule : ramp_stop_direction_ctrl
`default_nettype wire

// ==== sim/ramp_stop_direction_ctrl_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module ramp_stop_direction_ctrl_chk (
	// clock and reset
	input wire logic CLK,
	input wire logic SRST,
	// ramp outputs
	input wire logic [1:0] ACTIVE_SET,
	input wire logic [15:0] ACCEL_TIME,
	input wire logic [7:0] LOWER_ARC,
	input wire logic [7:0] UPPER_ARC,
	input wire logic [1:0] RAMP_SHAPE,
	// run outputs
	input wire logic RUN_FWD,
	input wire logic RUN_REV,
	input wire logic RAMP_STOP,
	input wire logic COAST,
	input wire logic DC_BRAKE,
	// braking outputs
	input wire logic REGEN_EN,
	input wire logic RES_PROTECT,
	input wire logic [15:0] BRK_OHMS
);
	logic [1:0] set_q;
	logic [8:0] gap_q;
	default clocking @(posedge CLK); endclocking
	default disable iff (SRST);
	// ====
	// edges since the active set last moved; saturates so long runs stay quiet
	always_ff @(posedge CLK) begin
		set_q <= ACTIVE_SET;
		if (SRST || ACTIVE_SET != set_q) begin
			gap_q <= 9'h000;
		end else if (gap_q != 9'h1FF) begin
			gap_q <= gap_q + 9'h001;
		end
	end
	// ====
	// properties
	coast_no_brake_a: assert property (COAST |-> !DC_BRAKE)
		else $error("dc braking while coasting");
	coast_no_run_a: assert property (COAST |-> !RUN_FWD && !RUN_REV && !RAMP_STOP)
		else $error("coasting while driven");
	brake_after_ramp_a: assert property ($rose(DC_BRAKE) |-> $past(RAMP_STOP))
		else $error("dc braking without a ramp stop before it");
	dir_exclusive_a: assert property (!(RUN_FWD && RUN_REV))
		else $error("both directions driven");
	set_legal_a: assert property (ACTIVE_SET inside {2'h1, 2'h2, 2'h3})
		else $error("active set out of range");
	set_spacing_a: assert property ($changed(ACTIVE_SET) |-> gap_q >= 9'd190)
		else $error("active set moved off a ramp step");
	arc_limit_a: assert property (LOWER_ARC <= 8'h32 && UPPER_ARC <= 8'h32)
		else $error("arc above fifty percent");
	time_limit_a: assert property (ACCEL_TIME <= 16'h7D00)
		else $error("ramp time above limit");
	shape_linear_a: assert property (ACTIVE_SET != 2'h1 |-> RAMP_SHAPE == 2'h0)
		else $error("shape outside set one");
	protect_regen_a: assert property (RES_PROTECT |-> REGEN_EN)
		else $error("resistor protection without braking");
	ohm_range_a: assert property (BRK_OHMS >= 16'h000A && BRK_OHMS <= 16'h2710)
		else $error("resistance out of range");
endmodule : ramp_stop_direction_ctrl_chk
bind ramp_stop_direction_ctrl ramp_stop_direction_ctrl_chk i_ramp_stop_direction_ctrl_chk (
	.CLK(CLK), .SRST(SRST), .ACTIVE_SET(ACTIVE_SET), .ACCEL_TIME(ACCEL_TIME),
	.LOWER_ARC(LOWER_ARC), .UPPER_ARC(UPPER_ARC), .RAMP_SHAPE(RAMP_SHAPE),
	.RUN_FWD(RUN_FWD), .RUN_REV(RUN_REV), .RAMP_STOP(RAMP_STOP), .COAST(COAST),
	.DC_BRAKE(DC_BRAKE), .REGEN_EN(REGEN_EN), .RES_PROTECT(RES_PROTECT), .BRK_OHMS(BRK_OHMS));
`default_nettype wire

// ==== sim/ramp_stop_motor.sv ====
`timescale 1ns/1ps
`default_nettype none
module ramp_stop_motor (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// drive commands
	input wire logic run_fwd,
	input wire logic run_rev,
	// bench override of shaft speed
	input wire logic preset_en,
	input wire logic [15:0] preset,
	// feedback
	output logic [15:0] out_freq,
	output logic stopped
);
	// ====
	// speed climbs while driven and decays otherwise, so stops take real time
	always_ff @(posedge clk) begin
		if (srst) begin
			out_freq <= 16'h0000;
		end else if (preset_en) begin
			out_freq <= preset;
		end else if (run_fwd || run_rev) begin
			out_freq <= (out_freq >= 16'h1000) ? 16'h1000 : out_freq + 16'h0040;
		end else begin
			out_freq <= (out_freq > 16'h0040) ? out_freq - 16'h0040 : 16'h0000;
		end
	end
	assign stopped = (out_freq == 16'h0000);
endmodule : ramp_stop_motor
`default_nettype wire

// ==== sim/test_ramp_stop_direction_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ramp_stop_consts.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; $display("unexpected at %0t: %h expected %h", $time, (a), (b)); end end
`define WAIT(e, m) begin n = 0; while (!(e) && n < m) begin @(posedge clk); n++; end if (n >= m) begin errors++; results(); end end
`define IDLE (!run_f && !run_r && !rstop && !coast && !dcb && mstop)
`define CFG wr(`OFS_CFG, {15'h0, c})
module test_ramp_stop_direction_ctrl import ramp_stop_pkg::*;;
	logic clk = 0, srst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic fwd = 0, rev = 0, jog = 0, fn5 = 0, fn64 = 0, ref0 = 0, pre_en = 0;
	logic [7:0] awaddr = 0, araddr = 0, lo, up;
	logic [31:0] wdata = 0, rdata;
	logic [1:0] src = 0, bresp, rresp, aset, shape;
	logic [15:0] pre_f = 0, acc, dec, ofreq, ohms, kw, seed = 16'h8829;
	logic awready, wready, bvalid, arready, rvalid, run_f, run_r, rstop, coast, dcb, regen, rprot, mstop;
	cfg_type c;
	int errors = 0, comparisons = 0;
	// ====
	// design and motor
	ramp_stop_direction_ctrl #(.TENTH_S_CYCLES(10)) i_ramp_stop_direction_ctrl (.CLK(clk), .SRST(srst),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.FWD_CMD(fwd), .REV_CMD(rev), .JOG_CMD(jog), .RAMP_SEL_FN5(fn5), .RAMP_SEL_FN64(fn64),
		.CMD_SOURCE(src), .OUT_FREQ(ofreq), .REF_ZERO(ref0), .MOTOR_STOPPED(mstop),
		.ACTIVE_SET(aset), .ACCEL_TIME(acc), .DECEL_TIME(dec), .LOWER_ARC(lo), .UPPER_ARC(up),
		.RAMP_SHAPE(shape), .RUN_FWD(run_f), .RUN_REV(run_r), .RAMP_STOP(rstop), .COAST(coast),
		.DC_BRAKE(dcb), .REGEN_EN(regen), .RES_PROTECT(rprot), .BRK_OHMS(ohms), .BRK_POWER(kw));
	ramp_stop_motor i_ramp_stop_motor (.clk(clk), .srst(srst), .run_fwd(run_f), .run_rev(run_r),
		.preset_en(pre_en), .preset(pre_f), .out_freq(ofreq), .stopped(mstop));
	// 200 MHz
	always #2.5 clk = ~clk;
	// ====
	// helpers
	task automatic results();
		$display("mismatches %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : results
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
	endtask : tick
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	// reference model of the ramp set choice
	function automatic int exp_set(cfg_type g, logic f5, logic f64, logic [15:0] f);
		case (g.mode)
			2'h0: return (g.ramp_set_select == 2'h0) ? 1 : int'(g.ramp_set_select);
			2'h1: return (f > 16'h1000) ? 3 : ((f > 16'h0800) ? 2 : 1);
			2'h2: return f64 ? 3 : (f5 ? 2 : 1);
			default: return (f > 16'h1000) ? 3 : (((f > 16'h0800) ^ f5) ? 2 : 1);
		endcase
	endfunction : exp_set
	// both address and data offered at once, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && n < 500);
		bready <= 1'b0;
		if (n >= 500) begin
			errors++;
			results();
		end
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (!rvalid && n < 500);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		if (n >= 500) begin
			errors++;
			results();
		end
	endtask : rd
	// ====
	// main sequence
	initial begin
		int n, s, g;
		logic [31:0] d;
		logic [1:0] r;
		tick(2);
		srst <= 1'b0;
		tick(2);
		`CHK(aset, 2'h1)
		`CHK({lo, up}, 16'h0A0A)
		`CHK({regen, rprot}, 2'h2)
		rd(`OFS_T2, d, r);
		`CHK(d, 32'h00C8_00C8)
		wr(`OFS_T2, 32'h7D01_7D01);
		rd(`OFS_T2, d, r);
		`CHK(d, 32'h7D00_7D00)
		wr(`OFS_ARC, 32'h3C3C_3C3C);
		rd(`OFS_ARC, d, r);
		`CHK(d, 32'h3232_3232)
		rd(8'h80, d, r);
		`CHK(r, `RESP_SLVERR)
		`CHK(d, 32'h0000_0000)
		wr(8'h80, 32'h0000_0001);
		`CHK(bresp, `RESP_SLVERR)
		wr(`OFS_BRK, 32'h0000_0005);
		tick(3);
		`CHK({kw, ohms}, 32'h0001_000A)
		wr(`OFS_BRK, 32'h0BB8_2710);
		tick(3);
		`CHK({kw, ohms}, 32'h0BB8_2710)
		c = '0;
		for (int i = 0; i < 3; i++) begin
			c.regen_brake_sel = i[1:0];
			`CFG;
			tick(3);
			`CHK({regen, rprot}, {i != 0, i == 1})
		end
		// distinct times per set, and distinct arcs for sets one and three, so the active one can be told apart
		wr(`OFS_T1, 32'h0012_0011);
		wr(`OFS_T2, 32'h0022_0021);
		wr(`OFS_T3, 32'h0032_0031);
		wr(`OFS_ARC, 32'h2827_1E1D);
		wr(`OFS_SWF, 32'h1000_0800);
		pre_en <= 1'b1;
		for (int k = 0; k < 32; k++) begin
			seed = lfsr(seed);
			c.mode = seed[1:0];
			c.ramp_set_select = seed[3:2];
			c.ramp_shape_set1 = seed[5:4];
			fn5 <= seed[6];
			fn64 <= seed[7];
			seed = lfsr(seed);
			pre_f <= {3'h0, seed[12:0]};
			`CFG;
			tick(`RAMP_STEP_CYCLES * 2 + 10);
			s = exp_set(c, fn5, fn64, pre_f);
			`CHK(aset, s[1:0])
			`CHK({acc, dec}, {10'h0, s[1:0], 4'h1, 10'h0, s[1:0], 4'h2})
			`CHK({lo, up}, (s == 3) ? 16'h2728 : 16'h1D1E)
			`CHK(shape, (s == 1) ? c.ramp_shape_set1 : 2'h0)
		end
		pre_en <= 1'b0;
		fn5 <= 1'b0;
		fn64 <= 1'b0;
		wr(`OFS_DCB, 32'h0002_0100);
		c = '0;
		c.regen_brake_sel = 2'h2;
		// every stop pattern against every command source
		for (int k = 0; k < 16; k++) begin
			c.stop_pattern_sel = k[3:2];
			src <= k[1:0];
			`CFG;
			fwd <= 1'b1;
			`WAIT(run_f, 100)
			tick(80);
			fwd <= 1'b0;
			`WAIT(coast || rstop, 50)
			g = (k == 4 || k == 9 || k == 14);
			`CHK(coast, g[0])
			`CHK(rstop, !g[0])
			s = 0;
			repeat (300) begin
				@(posedge clk);
				s = s | dcb;
			end
			`CHK(s[0], k < 4)
			`WAIT(`IDLE, 3000)
		end
		src <= 2'h1;
		for (int p = 1; p < 3; p++) begin
			c.direction_prohibit = p[1:0];
			`CFG;
			fwd <= (p == 2);
			rev <= (p == 1);
			tick(40);
			`CHK({run_f, run_r}, 2'h0)
			fwd <= 1'b0;
			rev <= 1'b0;
			tick(4);
		end
		c.direction_prohibit = 2'h0;
		for (int p = 0; p < 5; p++) begin
			c.fwd_rev_conflict_policy = p[2:0];
			`CFG;
			fwd <= 1'b1;
			tick(30);
			rev <= 1'b1;
			s = (p == 0 || p == 3) ? 1 : ((p == 1) ? 0 : 2);
			`WAIT({run_f, run_r} == s[1:0], 2000)
			tick(20);
			`CHK({run_f, run_r}, s[1:0])
			fwd <= 1'b0;
			rev <= 1'b0;
			`WAIT(`IDLE, 3000)
		end
		// reversal: plain, jog, analog curve two, run cleared first
		wr(`OFS_DEAD, 32'h0000_00FA);
		for (int k = 0; k < 4; k++) begin
			c.curve2 = (k == 2);
			c.freq_ai1 = (k == 2);
			`CFG;
			jog <= (k == 1);
			ref0 <= (k == 0);
			fwd <= 1'b1;
			`WAIT(run_f, 100)
			tick(80);
			fwd <= 1'b0;
			if (k == 3) `WAIT(`IDLE, 3000)
			rev <= 1'b1;
			g = 0;
			while (!run_r && g < 4000) begin
				@(posedge clk);
				g++;
			end
			`CHK(run_r, 1'b1)
			`CHK(g >= 2500, k == 0)
			// curve two: a 0 Hz reference keeps reverse although forward is asked
			if (k == 2) begin
				ref0 <= 1'b1;
				rev <= 1'b0;
				fwd <= 1'b1;
				tick(20);
				`CHK({run_f, run_r}, 2'h1)
				ref0 <= 1'b0;
				fwd <= 1'b0;
			end
			rev <= 1'b0;
			jog <= 1'b0;
			`WAIT(`IDLE, 3000)
		end
		results();
	end
endmodule : test_ramp_stop_direction_ctrl
`default_nettype wire
